/* verilog/signal_output_source_mux.sv */
// signal output source mux: register port, receive window and pin driver
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module signal_output_source_mux #(
  parameter int TEST_BUS_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // internal sources, same clock
  input wire logic [TEST_BUS_W-1:0] test_bus_in,
  input wire logic coder_env_in,
  input wire logic tx_serial_in,
  input wire logic rx_regen_in,
  input wire logic rx_serial_in,
  input wire logic b_rx_mod_in,
  input wire logic b_tx_mod_in,
  input wire logic demod_cmp_in,
  input wire logic a_rx_carrier_in,
  input wire logic a_tx_carrier_in,
  input wire logic a_rx_unfilt_in,
  input wire logic a_rx_env_in,
  // receive control from command logic
  input wire logic rx_start_in,
  input wire logic rx_frame_end_in,
  // pin and status outputs
  output logic general_signal_output_pin_out,
  output logic general_signal_output_pin_oe_out,
  output logic receiving_out,
  output logic [1:0] driver_select_out
);
  import general_signal_output_pin_pkg::*;

  // bit choice field is three bits wide, so more than eight lanes cannot be reached
  if (TEST_BUS_W < 1 || TEST_BUS_W > 8) begin : g_bad_width
    $error("TEST_BUS_W must be 1 to 8");
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] tx_source_q;
  logic [7:0] tx_source_d;
  logic [7:0] test_sel_q;
  logic [7:0] test_sel_d;
  logic [7:0] rx_ctrl_q;
  logic [7:0] rx_ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  rx_state_e rx_state_q;
  rx_state_e rx_state_d;
  logic pin_q;
  logic pin_d;
  logic pin_oe_q;
  logic pin_oe_d;

  // address decode
  wire hit_tx = (reg_addr_in == TRANSMIT_SOURCE_IDX);
  wire hit_tb = (reg_addr_in == TEST_SELECT_ONE_IDX);
  wire hit_rx = (reg_addr_in == RECEIVE_CTRL_IDX);
  wire hit_st = (reg_addr_in == STATUS_IDX);
  wire wr_tx = reg_wr_in && hit_tx;
  wire wr_tb = reg_wr_in && hit_tb;
  wire wr_rx = reg_wr_in && hit_rx;

  // register writes; reserved bits stay zero
  // select field storage
  assign tx_source_d = wr_tx ? (reg_wdata_in & RSV_MASK_TX[7:0]) : tx_source_q;
  assign test_sel_d = wr_tb ? (reg_wdata_in & RSV_MASK_TB[7:0]) : test_sel_q;
  assign rx_ctrl_d = wr_rx ? (reg_wdata_in & RSV_MASK_RX[7:0]) : rx_ctrl_q;

  // ***************************************************************
  // receive window
  // ***************************************************************
  wire keep_receiving_flag = rx_ctrl_q[KEEP_RX_BIT];
  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      RX_IDLE: begin
        if (rx_start_in) begin
          rx_state_d = RX_ACTIVE;
        end
      end
      RX_ACTIVE: begin
        // keep flag holds reception across frame ends
        if (rx_frame_end_in && !keep_receiving_flag && !rx_start_in) begin
          rx_state_d = RX_IDLE;
        end
      end
      default: begin
        rx_state_d = RX_IDLE;
      end
    endcase
  end
  wire rx_live = (rx_state_q == RX_ACTIVE);

  // ***************************************************************
  // source vector
  // ***************************************************************
  wire [3:0] output_pin_source_select = tx_source_q[SEL_LSB +: SEL_W];
  wire [TBB_W-1:0] test_bus_bit_choice = test_sel_q[TBB_LSB +: TBB_W];
  // out of range bit choice reads low rather than wrapping
  wire tb_ok = (32'(test_bus_bit_choice) < TEST_BUS_W);
  wire tb_bit = tb_ok ? test_bus_in[test_bus_bit_choice] : 1'b0;

  general_signal_output_pin_src_if src_bus ();
  assign src_bus.src[SRC_TRISTATE] = 1'b0;
  assign src_bus.src[SRC_LOW] = 1'b0;
  assign src_bus.src[SRC_HIGH] = 1'b1;
  assign src_bus.src[SRC_TEST_BUS] = tb_bit;
  assign src_bus.src[SRC_CODER_ENV] = coder_env_in;
  assign src_bus.src[SRC_TX_SERIAL] = tx_serial_in;
  // regenerated receive, gated by receive window
  assign src_bus.src[SRC_RX_REGEN] = rx_regen_in && rx_live;
  assign src_bus.src[SRC_RX_SERIAL] = rx_serial_in && rx_live;
  assign src_bus.src[SRC_B_RX_MOD] = b_rx_mod_in && rx_live;
  assign src_bus.src[SRC_B_TX_MOD] = b_tx_mod_in;
  assign src_bus.src[SRC_B_DEMOD_CMP] = demod_cmp_in;
  assign src_bus.src[SRC_B_RFU] = 1'b0;
  assign src_bus.src[SRC_A_RX_CARRIER] = a_rx_carrier_in && rx_live;
  assign src_bus.src[SRC_A_TX_CARRIER] = a_tx_carrier_in;
  assign src_bus.src[SRC_A_RX_UNFILT] = a_rx_unfilt_in;
  assign src_bus.src[SRC_A_RX_ENV] = a_rx_env_in;
  assign src_bus.sel = output_pin_source_select;

  general_signal_output_pin_selector u_selector (
    .bus(src_bus.chooser)
  );

  assign pin_d = src_bus.sel_val;
  assign pin_oe_d = src_bus.sel_oe;

  // ***************************************************************
  // read data
  // ***************************************************************
  wire [7:0] status_word = {7'h00, rx_live};
  assign rdata_d = !reg_rd_in ? 8'h00 :
                   hit_tx ? tx_source_q :
                   hit_tb ? test_sel_q :
                   hit_rx ? rx_ctrl_q :
                   hit_st ? status_word : 8'h00;

  // ***************************************************************
  // flops
  // ***************************************************************
  // register file; reset value of select is tristate
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_source_q <= TRANSMIT_SOURCE_RST;
      test_sel_q <= TEST_SELECT_ONE_RST;
      rx_ctrl_q <= RECEIVE_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      tx_source_q <= tx_source_d;
      test_sel_q <= test_sel_d;
      rx_ctrl_q <= rx_ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // receive state and pin, pin floats in reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_state_q <= RX_IDLE;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_q;
  assign general_signal_output_pin_out = pin_q;
  assign general_signal_output_pin_oe_out = pin_oe_q;
  // one-hot code: the active bit is the flop itself
  assign receiving_out = rx_state_q[1];
  assign driver_select_out = tx_source_q[DRV_LSB +: DRV_W];
endmodule // signal_output_source_mux

/* verilog/general_signal_output_pin_pkg.sv */
// package: register map, select codes and reset values for the signal output mux
package general_signal_output_pin_pkg;
  // ***************************************************************
  // register map (printed offsets are not all multiples of four)
  // ***************************************************************
  localparam logic [7:0] TRANSMIT_SOURCE_IDX = 8'h16;
  localparam logic [7:0] TEST_SELECT_ONE_IDX = 8'h31;
  localparam logic [7:0] RECEIVE_CTRL_IDX = 8'h32;
  localparam logic [7:0] STATUS_IDX = 8'h33;
  localparam logic [7:0] TRANSMIT_SOURCE_RST = 8'h10;
  localparam logic [7:0] TEST_SELECT_ONE_RST = 8'h00;
  localparam logic [7:0] RECEIVE_CTRL_RST = 8'h00;
  // field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int DRV_LSB = 4;
  localparam int DRV_W = 2;
  localparam int TBB_LSB = 0;
  localparam int TBB_W = 3;
  localparam int KEEP_RX_BIT = 0;
  localparam logic [31:0] RSV_MASK_TX = 32'h0000_003F;
  localparam logic [31:0] RSV_MASK_TB = 32'h0000_0007;
  localparam logic [31:0] RSV_MASK_RX = 32'h0000_0001;

  // ***************************************************************
  // output pin source codes
  // ***************************************************************
  typedef enum logic [3:0] {
    SRC_TRISTATE = 4'h0,
    SRC_LOW = 4'h1,
    SRC_HIGH = 4'h2,
    SRC_TEST_BUS = 4'h3,
    SRC_CODER_ENV = 4'h4,
    SRC_TX_SERIAL = 4'h5,
    SRC_RX_REGEN = 4'h6,
    SRC_RX_SERIAL = 4'h7,
    SRC_B_RX_MOD = 4'h8,
    SRC_B_TX_MOD = 4'h9,
    SRC_B_DEMOD_CMP = 4'hA,
    SRC_B_RFU = 4'hB,
    SRC_A_RX_CARRIER = 4'hC,
    SRC_A_TX_CARRIER = 4'hD,
    SRC_A_RX_UNFILT = 4'hE,
    SRC_A_RX_ENV = 4'hF
  } pin_source_e;

  // receive session states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_ACTIVE = 2'b10
  } rx_state_e;
endpackage

/* verilog/general_signal_output_pin_src_if.sv */
// interface: internal sources, four of them gated by the receive window, fed to the selector
`timescale 1ns/1ps
interface general_signal_output_pin_src_if;
  logic [15:0] src;
  logic [3:0] sel;
  logic sel_val;
  logic sel_oe;
  modport provider (output src, output sel, input sel_val, input sel_oe);
  modport chooser (input src, input sel, output sel_val, output sel_oe);
endinterface

/* verilog/general_signal_output_pin_selector.sv */
// combinational selector: one source code to a pin level and enable
`timescale 1ns/1ps
module general_signal_output_pin_selector (
  general_signal_output_pin_src_if.chooser bus
);
  import general_signal_output_pin_pkg::*;
  // single indexed pick; only the chosen bit reaches the flop behind
  wire picked = bus.src[bus.sel];
  wire tri_code = (bus.sel == SRC_TRISTATE);
  wire rfu_code = (bus.sel == SRC_B_RFU);
  assign bus.sel_val = (tri_code || rfu_code) ? 1'b0 : picked;
  assign bus.sel_oe = !tri_code;
endmodule // general_signal_output_pin_selector

/* tb/general_signal_output_pin_chk.sv */
// checker: port-level properties of the signal output mux
`timescale 1ns/1ps
module general_signal_output_pin_chk #(
  parameter int TEST_BUS_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [TEST_BUS_W-1:0] test_bus_in,
  input wire logic coder_env_in,
  input wire logic rx_start_in,
  input wire logic general_signal_output_pin_out,
  input wire logic general_signal_output_pin_oe_out,
  input wire logic receiving_out,
  input wire logic [1:0] driver_select_out
);
  logic [5:0] tx_q;
  logic [2:0] tbb_q;
  wire logic [3:0] sel_w = tx_q[3:0];
  wire logic pin_w = general_signal_output_pin_out;
  wire logic oe_w = general_signal_output_pin_oe_out;
  // shadow copies; reserved bits dropped like the design does
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_q <= 6'h10;
      tbb_q <= 3'h0;
    end else if (reg_wr_in && reg_addr_in == 8'h16) begin
      tx_q <= reg_wdata_in[5:0];
    end else if (reg_wr_in && reg_addr_in == 8'h31) begin
      tbb_q <= reg_wdata_in[2:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  reset_state_a: assert property (disable iff (1'b0) !rst_b_in |=> !oe_w && driver_select_out == 2'b01)
    else $error("pin enabled or driver select wrong after reset");
  tristate_code_a: assert property (sel_w == 4'h0 |=> !oe_w)
    else $error("pin driven while tristate selected");
  low_code_a: assert property (sel_w == 4'h1 |=> oe_w && !pin_w)
    else $error("pin not low for low code");
  high_code_a: assert property (sel_w == 4'h2 |=> oe_w && pin_w)
    else $error("pin not high one cycle after high code");
  test_bit_a: assert property (sel_w == 4'h3 && tbb_q < TEST_BUS_W |=> pin_w == $past(test_bus_in[tbb_q]))
    else $error("pin does not follow chosen test bus bit");
  coder_env_a: assert property (sel_w == 4'h4 |=> oe_w && pin_w == $past(coder_env_in))
    else $error("pin does not follow coder envelope");
  rx_gate_a: assert property (sel_w == 4'h6 && !receiving_out |=> !pin_w)
    else $error("receive output leaks outside receive");
  rx_start_a: assert property (rx_start_in |=> receiving_out)
    else $error("receive not entered after start");
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero without read");
endmodule // general_signal_output_pin_chk
bind signal_output_source_mux general_signal_output_pin_chk #(.TEST_BUS_W(TEST_BUS_W)) chk_u (.*);

/* tb/src_stub.sv */
// partner: far-side source patterns feeding the selector
`timescale 1ns/1ps
module src_stub (
  input wire logic flip_in,
  output logic [10:0] src_out,
  output logic [7:0] bus_out
);
  // complementary patterns, so a stuck ungated source shows in one of the two passes
  assign src_out = 11'h5A5 ^ {11{flip_in}};
  assign bus_out = 8'hA6 ^ {8{flip_in}};
endmodule // src_stub

/* tb/tb.sv */
// testbench: register access, every select code, receive window
`timescale 1ns/1ps
module tb;
  logic clk_in, rst_b_in, wr, rd, rx_start, fend, flip, pin, oe, rxing;
  logic [7:0] addr, wdata, rdata, tbus;
  logic [10:0] src;
  logic [1:0] drv;
  int error_cnt, cmp_count, cyc;
  src_stub src_u (.flip_in(flip), .src_out(src), .bus_out(tbus));
  signal_output_source_mux dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .test_bus_in(tbus), .coder_env_in(src[0]),
    .tx_serial_in(src[1]), .rx_regen_in(src[2]), .rx_serial_in(src[3]), .b_rx_mod_in(src[4]), .b_tx_mod_in(src[5]),
    .demod_cmp_in(src[6]), .a_rx_carrier_in(src[7]), .a_tx_carrier_in(src[8]), .a_rx_unfilt_in(src[9]),
    .a_rx_env_in(src[10]), .rx_start_in(rx_start), .rx_frame_end_in(fend), .general_signal_output_pin_out(pin),
    .general_signal_output_pin_oe_out(oe), .receiving_out(rxing), .driver_select_out(drv));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // hang guard, far above the roughly 120 cycles needed
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  // expected pin per code; codes 6, 7, 8 and 12 gated outside receive
  function automatic logic exp_pin(input int c, input logic rx);
    logic [15:0] v;
    v = {src[10:7], 1'b0, src[6:0], tbus[5], 3'b100};
    if (!rx && (c == 6 || c == 7 || c == 8 || c == 12))
      return 1'b0;
    return v[c];
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {rst_b_in, wr, rd, rx_start, fend, flip} = 6'h00;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk("oe", 8'h00, oe);
    chk("drv", 8'h01, drv);
    rd_reg(8'h16, 8'h10, "tx_src");
    rd_reg(8'h55, 8'h00, "unmapped");
    wr_reg(8'h16, 8'hFF);
    rd_reg(8'h16, 8'h3F, "tx_src_rsv");
    wr_reg(8'h31, 8'hFD);
    rd_reg(8'h31, 8'h05, "tb_sel");
    // no first-scheme mode is run, so codes 0110 and 0111 are fair here
    // pass 0 idle, pass 1 inverted sources while receiving
    for (int p = 0; p < 2; p++) begin
      flip <= p[0];
      if (p == 1) begin
        wr_reg(8'h32, 8'h01);
        rx_start <= 1'b1;
        @(posedge clk_in);
        rx_start <= 1'b0;
        fend <= 1'b1;
        @(posedge clk_in);
        fend <= 1'b0;
        #1;
        chk("rx_keep", 8'h01, rxing);
        rd_reg(8'h33, 8'h01, "status");
      end
      for (int c = 0; c < 16; c++) begin
        wr_reg(8'h16, {4'h1, c[3:0]});
        @(posedge clk_in);
        #1;
        chk("pin", {7'h00, exp_pin(c, p == 1)}, pin);
        chk("oe", {7'h00, c != 0}, oe);
      end
    end
    wr_reg(8'h32, 8'h00);
    fend <= 1'b1;
    @(posedge clk_in);
    fend <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("rx_end", 8'h00, rxing);
    final_report();
  end
endmodule // tb
